/* File: rtl/debug_phy_pkg.sv */
// Constants, types and state layout for the debug port physical-layer register set
package debug_phy_pkg;

    // Register offsets, debugger view
    localparam logic [3:0] OFS_REV_STATUS = 4'h0;
    localparam logic [3:0] OFS_ERR_STATUS = 4'h1;
    localparam logic [3:0] OFS_CTRL_A = 4'h2;
    localparam logic [3:0] OFS_CTRL_B = 4'h3;
    localparam logic [3:0] OFS_KEY_STATUS = 4'h7;
    localparam logic [3:0] OFS_RST_REQ = 4'h8;
    localparam logic [3:0] OFS_CLK_CTRL = 4'h9;
    localparam logic [3:0] OFS_SYS_CTRL_A = 4'ha;
    localparam logic [3:0] OFS_SYS_STATUS = 4'hb;
    localparam logic [3:0] OFS_CRC_STATUS = 4'hc;

    // Field positions
    localparam int PHY_CONTROL_A_INTER_BYTE_DELAY_ENABLE_BIT = 7;
    localparam int PHY_CONTROL_A_PARITY_CHECK_DISABLE_BIT = 5;
    localparam int PHY_CONTROL_A_DTD_BIT = 4;
    localparam int PHY_CONTROL_A_RSD_BIT = 3;
    localparam int PHY_CONTROL_B_NEGATIVE_ACK_DISABLE_BIT = 4;
    localparam int PHY_CONTROL_B_CCDIS_BIT = 3;
    localparam int PHY_CONTROL_B_PORTDIS_BIT = 2;
    localparam int KEY_UROW_BIT = 5;
    localparam int KEY_PROG_BIT = 4;
    localparam int KEY_ERASE_BIT = 3;
    localparam int SYS_CTRL_COMMIT_BIT = 1;
    localparam int SYS_CTRL_SYSTEM_CLOCK_REQUEST_BIT = 0;

    // Reset values and masks
    localparam logic [7:0] PHY_CONTROL_A_MASK = 8'hbf;
    localparam logic [2:0] PHY_CONTROL_B_MASK = 3'h6;
    localparam logic [7:0] RST_SIGNATURE = 8'h59;
    localparam logic [1:0] CLKSEL_DEFAULT = 2'h3;
    localparam logic [2:0] GUARD_OFF = 3'h7;
    localparam logic [7:0] GUARD_MAX_CYCLES = 8'h80;

    // Error signature codes
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_PARITY = 3'h1;
    localparam logic [2:0] ERR_FRAME = 3'h2;
    localparam logic [2:0] ERR_TIMEOUT = 3'h3;
    localparam logic [2:0] ERR_CLOCK = 3'h4;
    localparam logic [2:0] ERR_CONTENTION = 3'h7;

    // Transmit pacing states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_WAIT = 2'b01,
        TX_BUSY = 2'b10
    } tx_state_t;

    // Link errors seen by the physical layer, one-cycle pulses
    typedef struct packed {
        logic parity;
        logic frame;
        logic clock;
        logic contention;
    } link_err_t;

    // Live levels from the system domain
    typedef struct packed {
        logic in_reset;
        logic asleep;
        logic prog_ready;
        logic urow_ready;
        logic locked;
        logic [2:0] crc;
    } sys_state_t;

endpackage : debug_phy_pkg

/* File: rtl/debug_phy_regs.sv */
// Physical-layer control and status registers of the single-wire debug port
// Operation
// - Registers reachable only by debugger instructions; 0x0-0x3 physical, 0x4-0xC access layer.
// - Status register upper nibble holds a read-only four-bit revision.
// - Three-bit error signature loads on link errors and clears on debugger read.
// - Parity error code 1, stop bit error code 2, clock error code 4.
// - Access-layer silence gives code 3; line contention gives code 7; 5,6 reserved.
// - Inter-byte delay enable adds two idle characters between multi-byte load bytes.
// - First transmitted byte waits only the normal direction-change guard time.
// - Parity disable ignores received parity and raises no parity error.
// - Without timeout disable, flag access timeout after 65536 cycles with no response.
// - Response signature disable suppresses all response signatures.
// - Guard time 128 cycles halving per step to 2; code 7 turns it off.
// - Negative-acknowledge disable suppresses the reset-during-access signature.
// - Contention detect disable stops detecting and reporting line contention.
// - Writing port disable resets port, drops clock request, clears config and keys.
// - Key bit 5 shows user-row-write key; debugger may write it.
// - Key bit 4 shows programming key; clears when programming completes.
// - Writing signature 0x59 holds system reset; other values release; bit 0 reads held.
// - Clock select: 1 is 16 MHz, 2 is 8 MHz, 3 is 4 MHz default.
// - System reset active bit sets during system reset and clears on read.
// - Key bit 3 shows erase key; clears when erase completes.
module debug_phy_regs
    import debug_phy_pkg::*;
#(
    parameter logic [3:0] REVISION = 4'h2, // Arbitrary value
    parameter int TIMEOUT_CYCLES = 65536,
    parameter int IDLE_CHAR_CYCLES = 12
)(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register access from the link instruction decoder
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Port enable request from the link (enable sequence seen on the wire)
    input wire logic port_enable_i,
    // Link events
    input wire link_err_t link_err_i,
    input wire logic acc_req_i,
    input wire logic acc_resp_i,
    // Transmit pacing
    input wire logic tx_turn_i,
    input wire logic tx_req_i,
    input wire logic tx_multi_i,
    input wire logic tx_done_i,
    output logic tx_go_o,
    // Key activation and completion
    input wire logic key_erase_set_i,
    input wire logic key_prog_set_i,
    input wire logic key_urow_set_i,
    input wire logic erase_done_i,
    input wire logic prog_done_i,
    // System domain levels
    input wire sys_state_t sys_i,
    // Controls to the link and system
    output logic port_enabled_o,
    output logic port_clock_request_o,
    output logic [1:0] port_clock_select_o,
    output logic parity_check_enable_o,
    output logic contention_detect_enable_o,
    output logic response_signature_enable_o,
    output logic negative_ack_enable_o,
    output logic system_clock_request_o,
    output logic system_reset_request_o,
    output logic user_row_commit_o,
    output logic timeout_o,
    output logic key_erase_o,
    output logic key_prog_o,
    output logic key_urow_o
);

    localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYCLES - 1);
    localparam logic [7:0] GAP_CYCLES = 8'(2 * IDLE_CHAR_CYCLES);

    // All state of the block
    typedef struct packed {
        logic enabled;
        logic [7:0] ctrl_a;
        logic [2:0] ctrl_b;
        logic [2:0] err_sig;
        logic key_erase;
        logic key_prog;
        logic key_urow;
        logic rst_hold;
        logic [1:0] clk_sel;
        logic clk_req;
        logic commit;
        logic rst_seen;
        logic to_run;
        logic [TO_W-1:0] to_cnt;
        logic to_flag;
        tx_state_t tx_st;
        logic [7:0] tx_cnt;
        logic tx_go;
        logic [7:0] rdata;
        logic rvalid;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    logic parity_off;
    logic timeout_off;
    logic contention_off;
    logic [7:0] guard_cycles;
    logic [2:0] err_code;
    logic err_hit;
    logic to_expire;
    logic wr_ctrl_b_dis;

    // Decoded controls
    assign parity_off = st_ff.ctrl_a[PHY_CONTROL_A_PARITY_CHECK_DISABLE_BIT];
    assign timeout_off = st_ff.ctrl_a[PHY_CONTROL_A_DTD_BIT];
    assign contention_off = st_ff.ctrl_b[PHY_CONTROL_B_CCDIS_BIT - 2];
    assign wr_ctrl_b_dis = reg_wr_i && reg_addr_i == OFS_CTRL_B && reg_wdata_i[PHY_CONTROL_B_PORTDIS_BIT];

    // Guard length from the select field; the off code gives none at all
    always_comb
    begin
        if (st_ff.ctrl_a[2:0] == GUARD_OFF)
        begin
            guard_cycles = 8'h00;
        end
        else
        begin
            guard_cycles = GUARD_MAX_CYCLES >> st_ff.ctrl_a[2:0];
        end
    end

    // Timeout expires on the last counted cycle of an open request
    assign to_expire = st_ff.to_run && st_ff.to_cnt == TO_LAST && !acc_resp_i;

    // Error coding; when several strike at once the line-level fault wins
    always_comb
    begin
        err_code = ERR_NONE;
        err_hit = 1'b0;
        if (link_err_i.contention && !contention_off)
        begin
            err_code = ERR_CONTENTION;
            err_hit = 1'b1;
        end
        else if (link_err_i.clock)
        begin
            err_code = ERR_CLOCK;
            err_hit = 1'b1;
        end
        else if (link_err_i.frame)
        begin
            err_code = ERR_FRAME;
            err_hit = 1'b1;
        end
        else if (link_err_i.parity && !parity_off)
        begin
            err_code = ERR_PARITY;
            err_hit = 1'b1;
        end
        else if (to_expire && !timeout_off)
        begin
            err_code = ERR_TIMEOUT;
            err_hit = 1'b1;
        end
    end

    // Next state
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;
        nxt_st.commit = 1'b0;
        nxt_st.to_flag = 1'b0;
        nxt_st.tx_go = 1'b0;

        if (!st_ff.enabled)
        begin
            // Disabled port ignores the wire except the enable sequence
            if (port_enable_i)
            begin
                nxt_st.enabled = 1'b1;
                nxt_st.clk_sel = CLKSEL_DEFAULT;
                nxt_st.clk_req = 1'b1;
            end
        end
        else if (wr_ctrl_b_dis)
        begin
            // Port disable wipes configuration, keys and the held system reset
            nxt_st = '0;
            nxt_st.clk_sel = CLKSEL_DEFAULT;
        end
        else
        begin
            // Register reads; only the link decoder can reach this port
            if (reg_rd_i)
            begin
                nxt_st.rvalid = 1'b1;
                case (reg_addr_i)
                    OFS_REV_STATUS: nxt_st.rdata = {REVISION, 4'h0};
                    OFS_ERR_STATUS: nxt_st.rdata = {5'h00, st_ff.err_sig};
                    OFS_CTRL_A: nxt_st.rdata = st_ff.ctrl_a;
                    OFS_CTRL_B: nxt_st.rdata = {3'h0, st_ff.ctrl_b, 2'h0};
                    OFS_KEY_STATUS: nxt_st.rdata = {2'h0, st_ff.key_urow, st_ff.key_prog,
                                                    st_ff.key_erase, 3'h0};
                    OFS_RST_REQ: nxt_st.rdata = {7'h00, st_ff.rst_hold};
                    OFS_CLK_CTRL: nxt_st.rdata = {6'h00, st_ff.clk_sel};
                    OFS_SYS_CTRL_A: nxt_st.rdata = {7'h00, st_ff.clk_req};
                    OFS_SYS_STATUS: nxt_st.rdata = {2'h0, st_ff.rst_seen, sys_i.asleep, sys_i.prog_ready,
                                                    sys_i.urow_ready, 1'b0, sys_i.locked};
                    OFS_CRC_STATUS: nxt_st.rdata = {5'h00, sys_i.crc};
                    default: nxt_st.rdata = 8'h00;
                endcase
                // Read-to-clear fields; a new event below overrides the clear
                if (reg_addr_i == OFS_ERR_STATUS)
                begin
                    nxt_st.err_sig = ERR_NONE;
                end
                if (reg_addr_i == OFS_SYS_STATUS)
                begin
                    nxt_st.rst_seen = 1'b0;
                end
            end

            // Register writes; read-only and reserved locations drop the data
            if (reg_wr_i)
            begin
                case (reg_addr_i)
                    OFS_CTRL_A: nxt_st.ctrl_a = reg_wdata_i & PHY_CONTROL_A_MASK;
                    OFS_CTRL_B: nxt_st.ctrl_b = reg_wdata_i[4:2] & PHY_CONTROL_B_MASK;
                    OFS_KEY_STATUS:
                    begin
                        // Writing the user-row bit retires that key
                        if (reg_wdata_i[KEY_UROW_BIT])
                        begin
                            nxt_st.key_urow = 1'b0;
                        end
                    end
                    OFS_RST_REQ: nxt_st.rst_hold = reg_wdata_i == RST_SIGNATURE;
                    OFS_CLK_CTRL:
                    begin
                        // Reserved code 0 is refused and the old choice kept
                        if (reg_wdata_i[1:0] != 2'h0)
                        begin
                            nxt_st.clk_sel = reg_wdata_i[1:0];
                        end
                    end
                    OFS_SYS_CTRL_A:
                    begin
                        nxt_st.clk_req = reg_wdata_i[SYS_CTRL_SYSTEM_CLOCK_REQUEST_BIT];
                        nxt_st.commit = reg_wdata_i[SYS_CTRL_COMMIT_BIT] && st_ff.key_urow;
                    end
                    default: nxt_st.ctrl_a = nxt_st.ctrl_a;
                endcase
            end

            // Keys: completion clears, activation in the same cycle wins
            if (erase_done_i)
            begin
                nxt_st.key_erase = 1'b0;
            end
            if (prog_done_i)
            begin
                nxt_st.key_prog = 1'b0;
            end
            if (key_erase_set_i)
            begin
                nxt_st.key_erase = 1'b1;
            end
            if (key_prog_set_i)
            begin
                nxt_st.key_prog = 1'b1;
            end
            if (key_urow_set_i)
            begin
                nxt_st.key_urow = 1'b1;
            end

            // Sticky system reset seen, held reset counts too
            if (sys_i.in_reset || st_ff.rst_hold)
            begin
                nxt_st.rst_seen = 1'b1;
            end

            // Access-layer watchdog
            if (acc_resp_i)
            begin
                nxt_st.to_run = 1'b0;
            end
            else if (acc_req_i)
            begin
                nxt_st.to_run = 1'b1;
                nxt_st.to_cnt = '0;
            end
            else if (to_expire)
            begin
                nxt_st.to_run = 1'b0;
                nxt_st.to_flag = !timeout_off;
            end
            else if (st_ff.to_run)
            begin
                nxt_st.to_cnt = st_ff.to_cnt + TO_W'(1);
            end

            // Error signature load after any clear
            if (err_hit)
            begin
                nxt_st.err_sig = err_code;
            end

            // Transmit pacing: guard on turnaround, fixed gap between load bytes
            case (st_ff.tx_st)
                TX_IDLE:
                begin
                    if (tx_turn_i)
                    begin
                        nxt_st.tx_cnt = guard_cycles;
                        nxt_st.tx_st = TX_WAIT;
                    end
                end
                TX_WAIT:
                begin
                    if (st_ff.tx_cnt != 8'h00)
                    begin
                        nxt_st.tx_cnt = st_ff.tx_cnt - 8'h01;
                    end
                    else if (tx_req_i)
                    begin
                        nxt_st.tx_go = 1'b1;
                        nxt_st.tx_st = TX_BUSY;
                    end
                    else if (tx_turn_i)
                    begin
                        nxt_st.tx_st = TX_IDLE;
                    end
                end
                TX_BUSY:
                begin
                    if (tx_done_i)
                    begin
                        // Gap only between bytes of a multi-byte load
                        nxt_st.tx_cnt = (st_ff.ctrl_a[PHY_CONTROL_A_INTER_BYTE_DELAY_ENABLE_BIT] && tx_multi_i) ? GAP_CYCLES : 8'h00;
                        nxt_st.tx_st = tx_multi_i ? TX_WAIT : TX_IDLE;
                    end
                end
                default: nxt_st.tx_st = TX_IDLE;
            endcase
        end
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            st_ff <= '0;
            st_ff.clk_sel <= CLKSEL_DEFAULT;
        end
        else if (ce_i)
        begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state flops
    assign reg_rdata_o = st_ff.rdata;
    assign reg_rvalid_o = st_ff.rvalid;
    assign tx_go_o = st_ff.tx_go;
    assign port_enabled_o = st_ff.enabled;
    assign port_clock_request_o = st_ff.enabled;
    assign port_clock_select_o = st_ff.clk_sel;
    assign parity_check_enable_o = !st_ff.ctrl_a[PHY_CONTROL_A_PARITY_CHECK_DISABLE_BIT];
    assign contention_detect_enable_o = !st_ff.ctrl_b[PHY_CONTROL_B_CCDIS_BIT - 2];
    assign response_signature_enable_o = !st_ff.ctrl_a[PHY_CONTROL_A_RSD_BIT];
    assign negative_ack_enable_o = !st_ff.ctrl_b[PHY_CONTROL_B_NEGATIVE_ACK_DISABLE_BIT - 2];
    assign system_clock_request_o = st_ff.clk_req;
    assign system_reset_request_o = st_ff.rst_hold;
    assign user_row_commit_o = st_ff.commit;
    assign timeout_o = st_ff.to_flag;
    assign key_erase_o = st_ff.key_erase;
    assign key_prog_o = st_ff.key_prog;
    assign key_urow_o = st_ff.key_urow;

endmodule : debug_phy_regs

/* File: sim/debug_phy_regs_sva.sv */
// Assertion checker for the debug port register set
module debug_phy_regs_sva
    import debug_phy_pkg::*;
#(
    parameter logic [3:0] REVISION = 4'h2,
    parameter int TIMEOUT_CYCLES = 65536
)(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic acc_req_i,
    input wire logic acc_resp_i,
    input wire logic tx_req_i,
    input wire logic tx_go_o,
    input wire logic port_enabled_o,
    input wire logic port_clock_request_o,
    input wire logic [1:0] port_clock_select_o,
    input wire logic contention_detect_enable_o,
    input wire logic negative_ack_enable_o,
    input wire logic system_reset_request_o,
    input wire logic timeout_o,
    input wire logic key_prog_o,
    input wire logic key_urow_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    logic wr_ok;
    logic armed_ff;
    logic [31:0] wait_ff;
    logic [7:0] wd_ff;
    // A write only counts while the port runs and is enabled
    assign wr_ok = reg_wr_i && ce_i && port_enabled_o;

    // Age of the last unanswered access request; free running so it never needs a reset
    always_ff @(posedge clock_i)
    begin
        armed_ff <= (rst_i || acc_resp_i) ? 1'b0 : (armed_ff || (acc_req_i && ce_i));
        wait_ff <= acc_req_i ? 32'h0 : wait_ff + 32'h1;
        wd_ff <= reg_wdata_i;
    end

    rvalid_follows_read_a: assert property (reg_rd_i && ce_i && port_enabled_o |=> reg_rvalid_o)
        else $error("read strobe not answered");
    rvalid_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("read answer without a read");
    revision_read_a: assert property (reg_rd_i && ce_i && port_enabled_o && reg_addr_i == OFS_REV_STATUS
        |=> reg_rdata_o == {REVISION, 4'h0}) else $error("revision status wrong");
    disable_clears_a: assert property (wr_ok && reg_addr_i == OFS_CTRL_B && reg_wdata_i[PHY_CONTROL_B_PORTDIS_BIT]
        |=> !port_enabled_o && !port_clock_request_o && !key_prog_o && !key_urow_o && !system_reset_request_o)
        else $error("port disable left state behind");
    reset_request_a: assert property (wr_ok && reg_addr_i == OFS_RST_REQ
        |=> system_reset_request_o == (wd_ff == RST_SIGNATURE)) else $error("system reset request wrong");
    ctrl_b_enables_a: assert property (wr_ok && reg_addr_i == OFS_CTRL_B && !reg_wdata_i[PHY_CONTROL_B_PORTDIS_BIT]
        |=> negative_ack_enable_o == !wd_ff[PHY_CONTROL_B_NEGATIVE_ACK_DISABLE_BIT]
        && contention_detect_enable_o == !wd_ff[PHY_CONTROL_B_CCDIS_BIT]) else $error("control b enables wrong");
    clock_code_zero_a: assert property (wr_ok && reg_addr_i == OFS_CLK_CTRL && reg_wdata_i[1:0] == 2'h0
        |=> $stable(port_clock_select_o)) else $error("reserved clock code taken");
    timeout_bound_a: assert property (timeout_o
        |-> armed_ff && wait_ff >= TIMEOUT_CYCLES - 1 && wait_ff <= TIMEOUT_CYCLES + 1)
        else $error("timeout at wrong moment");
    go_needs_request_a: assert property (tx_go_o |-> $past(tx_req_i) ##1 !tx_go_o)
        else $error("send permission without request");
endmodule : debug_phy_regs_sva

bind debug_phy_regs debug_phy_regs_sva #(.REVISION(REVISION), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_sva (
    .clock_i, .rst_i, .ce_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
    .acc_req_i, .acc_resp_i, .tx_req_i, .tx_go_o, .port_enabled_o, .port_clock_request_o, .port_clock_select_o,
    .contention_detect_enable_o, .negative_ack_enable_o, .system_reset_request_o, .timeout_o, .key_prog_o,
    .key_urow_o);

/* File: sim/link_partner.sv */
// Behavioural model of the link side: access layer and byte transmitter
module link_partner
#(
    parameter int RESP_DELAY = 5,
    parameter int BYTE_CYCLES = 4
)(
    input wire logic clock_i,
    input wire logic answer_i,
    input wire logic acc_req_i,
    input wire logic tx_go_i,
    output logic acc_resp_o,
    output logic tx_done_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        acc_resp_o = 1'b0;
        tx_done_o = 1'b0;
    end

    // Access layer answers after a delay, or stays silent as an asleep system would
    always @(posedge clock_i)
        if (acc_req_i && answer_i)
        begin
            repeat (RESP_DELAY) @(posedge clock_i);
            #1 acc_resp_o = 1'b1;
            @(posedge clock_i);
            #1 acc_resp_o = 1'b0;
        end

    // One byte on the wire per permission, finished after a fixed time
    always @(posedge clock_i)
        if (tx_go_i)
        begin
            repeat (BYTE_CYCLES - 1) @(posedge clock_i);
            #1 tx_done_o = 1'b1;
            @(posedge clock_i);
            #1 tx_done_o = 1'b0;
        end
endmodule : link_partner

/* File: sim/tb_top.sv */
// Self-checking bench for the debug port register set
module tb_top
    import debug_phy_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TO = 64;
    localparam int IDLE = 12;
    localparam logic [3:0] REV = 4'h2;

    logic clock_i = 0, rst_i = 1, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0, tx_req_i = 0, tx_multi_i = 0, answer = 1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [11:0] ev = 12'h000; // Event pulses: keys, dones, turn, request, enable, link errors
    sys_state_t sys_i = '0;
    logic [7:0] rdata;
    logic rvalid, go, resp, done, en, creq, pe, ce, rse, nke, sck, srq, commit, tmo, ke, kp, ku;
    logic [1:0] csel;
    int n_errors = 0, comparisons = 0, cycles = 0, n_to = 0, n;
    logic [2:0] codes [4] = '{ERR_PARITY, ERR_FRAME, ERR_CLOCK, ERR_CONTENTION};
    logic [2:0] sel_tab [3] = '{3'h0, 3'h6, 3'h7};
    int gt_tab [3] = '{128, 2, 0};

    debug_phy_regs #(.TIMEOUT_CYCLES(TO), .IDLE_CHAR_CYCLES(IDLE)) u_dut (.clock_i(clock_i), .rst_i(rst_i),
        .ce_i(ce_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .port_enable_i(ev[7]), .link_err_i(link_err_t'(ev[11:8])),
        .acc_req_i(ev[6]), .acc_resp_i(resp), .tx_turn_i(ev[5]), .tx_req_i(tx_req_i), .tx_multi_i(tx_multi_i),
        .tx_done_i(done), .tx_go_o(go), .key_erase_set_i(ev[0]), .key_prog_set_i(ev[1]), .key_urow_set_i(ev[2]),
        .erase_done_i(ev[3]), .prog_done_i(ev[4]), .sys_i(sys_i), .port_enabled_o(en), .port_clock_request_o(creq),
        .port_clock_select_o(csel), .parity_check_enable_o(pe), .contention_detect_enable_o(ce),
        .response_signature_enable_o(rse), .negative_ack_enable_o(nke), .system_clock_request_o(sck),
        .system_reset_request_o(srq), .user_row_commit_o(commit), .timeout_o(tmo), .key_erase_o(ke),
        .key_prog_o(kp), .key_urow_o(ku));

    link_partner u_link (.clock_i(clock_i), .answer_i(answer), .acc_req_i(ev[6]), .tx_go_i(go),
        .acc_resp_o(resp), .tx_done_o(done));

    initial
    begin
        forever #2.5 clock_i = ~clock_i;
    end

    // Cycle ceiling against hangs, and a tally of timeout pulses
    always @(posedge clock_i)
    begin
        cycles++;
        n_to += int'(tmo === 1'b1);
        if (cycles == 20000)
        begin
            n_errors++;
            close_out();
        end
    end

    task automatic tick();
        @(posedge clock_i);
        #1;
    endtask : tick

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        tick();
        reg_wr_i = 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        tick();
        reg_rd_i = 1'b0;
        chk1("rvalid", 1'b1, rvalid);
        chk8($sformatf("register %h", a), exp, rdata);
        tick();
    endtask : rd

    task automatic pulse(input int i);
        ev[i] = 1'b1;
        tick();
        ev[i] = 1'b0;
    endtask : pulse

    task automatic wait_go();
        n = 0;
        while (go !== 1'b1 && n < 300)
        begin
            tick();
            n++;
        end
    endtask : wait_go

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (3) tick();
        rst_i = 1'b0;
        chk8("clock select", 8'h03, {6'h0, csel});
        pulse(7);
        chk1("clock request", 1'b1, sck);
        wr(OFS_REV_STATUS, 8'hff);
        rd(OFS_REV_STATUS, {REV, 4'h0});
        for (int k = 0; k < 4; k++)
        begin
            pulse(11 - k);
            rd(OFS_ERR_STATUS, {5'h0, codes[k]});
            rd(OFS_ERR_STATUS, 8'h00);
        end
        wr(OFS_CTRL_A, 8'h20);
        chk1("parity enable", 1'b0, pe);
        pulse(11);
        rd(OFS_ERR_STATUS, 8'h00);
        wr(OFS_CTRL_A, 8'hff);
        rd(OFS_CTRL_A, PHY_CONTROL_A_MASK);
        chk1("signature enable", 1'b0, rse);
        wr(OFS_CTRL_B, 8'h18);
        pulse(8);
        rd(OFS_ERR_STATUS, 8'h00);
        wr(OFS_CTRL_B, 8'h00);
        tick();
        for (int a = 4; a < 7; a++)
        begin
            wr(4'(a), 8'hff);
            rd(4'(a), 8'h00);
        end
        // Silent access layer, answered request, then detection off
        wr(OFS_CTRL_A, 8'h00);
        answer = 1'b0;
        pulse(6);
        repeat (TO + 4) tick();
        rd(OFS_ERR_STATUS, {5'h0, ERR_TIMEOUT});
        answer = 1'b1;
        pulse(6);
        repeat (2 * TO) tick();
        answer = 1'b0;
        wr(OFS_CTRL_A, 8'h10);
        pulse(6);
        repeat (2 * TO) tick();
        chk8("timeouts", 8'h01, n_to[7:0]);
        answer = 1'b1;
        wr(OFS_RST_REQ, RST_SIGNATURE);
        rd(OFS_RST_REQ, 8'h01);
        sys_i = 8'b1101_1010;
        tick();
        sys_i.in_reset = 1'b0;
        wr(OFS_RST_REQ, 8'h00);
        rd(OFS_RST_REQ, 8'h00);
        rd(OFS_SYS_STATUS, 8'h35);
        rd(OFS_SYS_STATUS, 8'h15);
        rd(OFS_CRC_STATUS, 8'h02);
        wr(OFS_CLK_CTRL, 8'h01);
        tick();
        wr(OFS_CLK_CTRL, 8'h00);
        rd(OFS_CLK_CTRL, 8'h01);
        wr(OFS_CLK_CTRL, 8'h02);
        chk8("clock select", 8'h02, {6'h0, csel});
        pulse(1);
        rd(OFS_KEY_STATUS, 8'h10);
        pulse(4);
        rd(OFS_KEY_STATUS, 8'h00);
        pulse(0);
        chk1("erase key", 1'b1, ke);
        rd(OFS_KEY_STATUS, 8'h08);
        pulse(3);
        rd(OFS_KEY_STATUS, 8'h00);
        pulse(2);
        rd(OFS_KEY_STATUS, 8'h20);
        wr(OFS_SYS_CTRL_A, 8'h03);
        chk1("commit", 1'b1, commit);
        wr(OFS_KEY_STATUS, 8'h20);
        rd(OFS_KEY_STATUS, 8'h00);
        // Guard time per code, then the gap between bytes of one load
        for (int k = 0; k < 3; k++)
        begin
            tx_req_i = 1'b1;
            tx_multi_i = 1'b1;
            wr(OFS_CTRL_A, {5'h10, sel_tab[k]});
            pulse(5);
            wait_go();
            chk8("guard", 8'(gt_tab[k] + 1), n[7:0]);
            tick();
            wait_go();
            chk1("byte gap", 1'b1, n >= 2 * IDLE);
            tx_req_i = 1'b0;
            tx_multi_i = 1'b0;
            repeat (8) tick();
        end
        ce_i = 1'b0;
        pulse(0);
        ce_i = 1'b1;
        chk1("erase key", 1'b0, ke);
        pulse(1);
        wr(OFS_CTRL_B, 8'h04);
        chk1("port enabled", 1'b0, en);
        pulse(7);
        rd(OFS_CTRL_A, 8'h00);
        rd(OFS_KEY_STATUS, 8'h00);
        close_out();
    end
endmodule : tb_top
